// *** src/i2rs_slave.sv ***
// How it works
// [R1] Master writes address then register index first.
// [R2] Master then repeats start with read address.
// [R3] Acknowledge read address, then send indexed register.
// [R4] Master ends reads with NACK then STOP.
// [R5] NACK is released data; stop driving then.
// [R6] Receiver holds data low on ninth clock.
// [R7] Falling data with clock high starts address.
// [R8] Rising data with clock high returns idle.
// [R9] Secondary accelerometer port also uses open-drain signalling.
// [R10] Level select one means main supply reference.
// [R11] Level select clears to zero at reset.
// [R12] Address is fixed six bits plus pin.
// [R13] Direction zero writes; address, index, data acknowledged. The code NACKs a data byte while the write buffer is full.
// [R14] Further written bytes go to next index.
// [R15] Acknowledged read bytes advance index, send next.
// [R16] Ignore traffic after foreign address until start/stop.
`timescale 1ns/10ps
`default_nettype none
`include "i2rs_regs.svh"
module i2rs_slave (
    input wire logic clk, // System clock, 25 MHz.
    input wire logic rst_b, // Asynchronous reset, active low.
    input wire logic scl_in, // Bus clock level.
    input wire logic sda_in, // Bus data level.
    output logic sda_out, // Data drive value, always low.
    output logic sda_oe, // High while pulling data low.
    input wire logic address_select_pin, // Lowest slave address bit.
    output logic [7:0] rd_index, // Index of the register being read.
    input wire logic [7:0] rd_data, // Register contents at rd_index.
    output logic wr_valid, // A written byte is offered.
    output logic [7:0] wr_index, // Index of the offered byte.
    output logic [7:0] wr_data, // Offered byte.
    input wire logic wr_ready, // User takes the offered byte.
    output logic aux_io_level_select, // Secondary pins on main supply.
    input wire logic secondary_bus_clock_in, // Secondary clock level.
    output logic secondary_bus_clock_out, // Secondary clock drive value.
    output logic secondary_bus_clock_oe, // Secondary clock drive enable.
    input wire logic secondary_bus_data_in, // Secondary data level.
    output logic secondary_bus_data_out, // Secondary data drive value.
    output logic secondary_bus_data_oe // Secondary data drive enable.
);
    i2rs_pkg::i2rs_state_t state;
    i2rs_pkg::i2rs_state_t next_state;
    i2rs_pkg::i2rs_phase_t phase;
    i2rs_pkg::i2rs_phase_t next_phase;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [7:0] txsh;
    logic [7:0] next_txsh;
    logic [7:0] register_index;
    logic [7:0] next_register_index;
    logic ack_flag;
    logic next_ack_flag;
    logic is_read;
    logic next_is_read;
    logic next_sda_oe;
    logic scl_q;
    logic sda_q;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic own_addr;
    logic next_wr_valid;
    logic [7:0] next_wr_index;
    logic [7:0] next_wr_data;
    logic next_aux;
    logic take;

    i2rs_stream_if #(.WIDTH(`I2RS_FIFO_WIDTH)) push_s ();
    i2rs_stream_if #(.WIDTH(`I2RS_FIFO_WIDTH)) pop_s ();

    // Byte returned for an index; the level select register is read back here.
    function automatic logic [7:0] read_byte(input logic [7:0] idx, input logic [7:0] ext,
                                             input logic aux);
        logic [7:0] val;
        val = ext;
        if (idx == `I2RS_AUX_INDEX) begin
            val = 8'h00;
            val[`I2RS_AUX_BIT] = aux;
        end
        return val;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus condition detection on the previous and present line levels.
    assign scl_rise = scl_in && !scl_q;
    assign scl_fall = !scl_in && scl_q;
    assign start_seen = scl_in && scl_q && sda_q && !sda_in; // see [R7]
    assign stop_seen = scl_in && scl_q && !sda_q && sda_in; // see [R8]
    assign own_addr = (shreg[7:1] == {`I2RS_ADDR_HI, address_select_pin}); // see [R12]

    // The secondary port is an open-drain pair, always released.
    assign secondary_bus_clock_out = 1'b0; // see [R9]
    assign secondary_bus_clock_oe = 1'b0;
    assign secondary_bus_data_out = 1'b0;
    assign secondary_bus_data_oe = 1'b0;
    assign sda_out = 1'b0;
    assign rd_index = register_index;

    ////////////////////////////////////////////////////////////////////////
    // Byte engine next state.
    always_comb begin
        next_state = state;
        next_phase = phase;
        next_cnt = cnt;
        next_shreg = shreg;
        next_txsh = txsh;
        next_register_index = register_index;
        next_ack_flag = ack_flag;
        next_is_read = is_read;
        push_s.valid = 1'b0;
        push_s.data = {register_index, shreg};
        if (start_seen) begin
            next_state = i2rs_pkg::ST_RX; // see [R7]
            next_phase = i2rs_pkg::PH_ADDR;
            next_cnt = 4'h0;
            next_ack_flag = 1'b0;
        end else if (stop_seen) begin
            next_state = i2rs_pkg::ST_IDLE; // see [R8]
            next_ack_flag = 1'b0;
        end else begin
            case (state)
                i2rs_pkg::ST_RX: begin
                    if (scl_rise && cnt != `I2RS_BYTE_BITS) begin
                        next_shreg = {shreg[6:0], sda_in};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && cnt == `I2RS_BYTE_BITS) begin
                        next_cnt = 4'h0;
                        next_state = i2rs_pkg::ST_ACK;
                        case (phase)
                            i2rs_pkg::PH_ADDR: begin
                                if (own_addr) begin
                                    next_ack_flag = 1'b1; // see [R6]
                                    next_is_read = shreg[0]; // see [R13]
                                    next_phase = i2rs_pkg::PH_INDEX;
                                end else begin
                                    next_state = i2rs_pkg::ST_IGNORE; // see [R16]
                                end
                            end
                            i2rs_pkg::PH_INDEX: begin
                                next_register_index = shreg; // see [R1]
                                next_ack_flag = 1'b1;
                                next_phase = i2rs_pkg::PH_DATA;
                            end
                            default: begin
                                // A full buffer refuses the byte with a NACK.
                                next_ack_flag = push_s.ready;
                                push_s.valid = push_s.ready;
                                if (push_s.ready) begin
                                    next_register_index = register_index + 8'h01; // see [R14]
                                end
                            end
                        endcase
                    end
                end
                i2rs_pkg::ST_ACK: begin
                    if (scl_fall) begin
                        next_ack_flag = 1'b0;
                        if (!ack_flag) begin
                            next_state = i2rs_pkg::ST_IGNORE;
                        end else if (is_read) begin
                            next_state = i2rs_pkg::ST_TX; // see [R3]
                            next_txsh = read_byte(register_index, rd_data, aux_io_level_select);
                            next_cnt = 4'h0;
                        end else begin
                            next_state = i2rs_pkg::ST_RX;
                        end
                    end
                end
                i2rs_pkg::ST_TX: begin
                    if (scl_fall) begin
                        if (cnt == `I2RS_LAST_BIT) begin
                            next_state = i2rs_pkg::ST_TXACK;
                        end else begin
                            next_txsh = {txsh[6:0], 1'b0};
                            next_cnt = cnt + 4'h1;
                        end
                    end
                end
                i2rs_pkg::ST_TXACK: begin
                    if (scl_rise) begin
                        if (sda_in) begin
                            next_state = i2rs_pkg::ST_IGNORE; // see [R5]
                        end else begin
                            next_register_index = register_index + 8'h01; // see [R15]
                        end
                    end else if (scl_fall) begin
                        next_state = i2rs_pkg::ST_TX;
                        next_txsh = read_byte(register_index, rd_data, aux_io_level_select);
                        next_cnt = 4'h0;
                    end
                end
                default: begin
                    next_state = state;
                end
            endcase
        end
        // Data is pulled low only for an acknowledge or a zero read bit.
        next_sda_oe = (next_state == i2rs_pkg::ST_ACK && next_ack_flag)
                      || (next_state == i2rs_pkg::ST_TX && !next_txsh[7]);
    end

    // Byte engine registers.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= i2rs_pkg::ST_IDLE;
            phase <= i2rs_pkg::PH_ADDR;
            cnt <= 4'h0;
            shreg <= 8'h00;
            txsh <= 8'h00;
            register_index <= 8'h00;
            ack_flag <= 1'b0;
            is_read <= 1'b0;
            sda_oe <= 1'b0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            state <= next_state;
            phase <= next_phase;
            cnt <= next_cnt;
            shreg <= next_shreg;
            txsh <= next_txsh;
            register_index <= next_register_index;
            ack_flag <= next_ack_flag;
            is_read <= next_is_read;
            sda_oe <= next_sda_oe;
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Written bytes wait in the buffer until the user side takes them.
    i2rs_fifo #(.WIDTH(`I2RS_FIFO_WIDTH), .DEPTH(`I2RS_FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .rst_b(rst_b),
        .in_s(push_s),
        .out_s(pop_s)
    );

    // Output stage refills whenever it is empty or being taken.
    assign pop_s.ready = !wr_valid || wr_ready;
    assign take = wr_valid && wr_ready;
    always_comb begin
        next_wr_valid = wr_valid;
        next_wr_index = wr_index;
        next_wr_data = wr_data;
        next_aux = aux_io_level_select;
        if (take && wr_index == `I2RS_AUX_INDEX) begin
            next_aux = wr_data[`I2RS_AUX_BIT]; // see [R10]
        end
        if (pop_s.ready) begin
            next_wr_valid = pop_s.valid;
            if (pop_s.valid) begin
                next_wr_index = pop_s.data[15:8];
                next_wr_data = pop_s.data[7:0];
            end
        end
    end

    // Output stage and level select registers.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_valid <= 1'b0;
            wr_index <= 8'h00;
            wr_data <= 8'h00;
            aux_io_level_select <= `I2RS_AUX_RESET; // see [R11]
        end else begin
            wr_valid <= next_wr_valid;
            wr_index <= next_wr_index;
            wr_data <= next_wr_data;
            aux_io_level_select <= next_aux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the engine.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    start_rx_a: assert property (start_seen |=> state == i2rs_pkg::ST_RX && cnt == 4'h0 // see [R7]
        && phase == i2rs_pkg::PH_ADDR) else $error("start did not begin address");
    stop_idle_a: assert property (stop_seen |=> state == i2rs_pkg::ST_IDLE && !sda_oe) // see [R8]
        else $error("stop did not return to idle");
    addr_ack_a: assert property (state == i2rs_pkg::ST_RX && phase == i2rs_pkg::PH_ADDR // see [R6]
        && scl_fall && cnt == 4'h8 && own_addr && !start_seen && !stop_seen |=> sda_oe)
        else $error("own address not acknowledged");
    foreign_quiet_a: assert property (state == i2rs_pkg::ST_IGNORE && !start_seen // see [R16]
        |=> !sda_oe && state != i2rs_pkg::ST_RX) else $error("foreign traffic answered");
    nack_free_a: assert property (state == i2rs_pkg::ST_TXACK && scl_rise && sda_in // see [R5]
        && !start_seen |=> !sda_oe [*2]) else $error("drive kept after nack");
    burst_step_a: assert property (state == i2rs_pkg::ST_TXACK && scl_rise && !sda_in // see [R15]
        && !start_seen && !stop_seen |=> register_index == $past(register_index) + 8'h01)
        else $error("read index not advanced");
    index_load_a: assert property (state == i2rs_pkg::ST_RX // see [R1]
        && phase == i2rs_pkg::PH_INDEX && scl_fall && cnt == 4'h8 && !start_seen && !stop_seen
        |=> register_index == $past(shreg)) else $error("index not loaded");
    write_step_a: assert property (push_s.valid // see [R14]
        |=> register_index == $past(register_index) + 8'h01 ##0 ack_flag)
        else $error("write index not advanced");
    read_send_a: assert property (state == i2rs_pkg::ST_ACK && is_read && ack_flag // see [R3]
        && scl_fall && !start_seen && !stop_seen
        |=> state == i2rs_pkg::ST_TX && sda_oe == !txsh[7])
        else $error("read data not sent");
    level_set_a: assert property (take && wr_index == `I2RS_AUX_INDEX // see [R10]
        |=> aux_io_level_select == $past(wr_data[`I2RS_AUX_BIT])) else $error("level not set");
endmodule // i2rs_slave
`default_nettype wire

// *** src/i2rs_regs.svh ***
`ifndef I2RS_REGS_SVH
`define I2RS_REGS_SVH
// Fixed upper six bits of the seven-bit slave address.
`define I2RS_ADDR_HI 6'h34
// Register index that holds the secondary bus level select bit.
`define I2RS_AUX_INDEX 8'h13
// Bit position of the level select inside that register.
`define I2RS_AUX_BIT 2
// Power-on value of the level select bit.
`define I2RS_AUX_RESET 1'b0
// Depth and width of the write buffer.
`define I2RS_FIFO_DEPTH 8
`define I2RS_FIFO_WIDTH 16
// Last bit number of a byte, counted from zero.
`define I2RS_LAST_BIT 4'h7
// Bit count at which a received byte is complete.
`define I2RS_BYTE_BITS 4'h8
`endif

// *** src/i2rs_pkg.sv ***
package i2rs_pkg;
    // Byte engine states, one-hot.
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_RX = 6'h02,
        ST_ACK = 6'h04,
        ST_TX = 6'h08,
        ST_TXACK = 6'h10,
        ST_IGNORE = 6'h20
    } i2rs_state_t;
    // Meaning of the next received byte, one-hot.
    typedef enum logic [2:0] {
        PH_ADDR = 3'h1,
        PH_INDEX = 3'h2,
        PH_DATA = 3'h4
    } i2rs_phase_t;
endpackage

// *** src/i2rs_stream_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// Valid and ready word stream between the slave and its buffer.
interface i2rs_stream_if #(parameter int WIDTH = 16);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** src/i2rs_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none
module i2rs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk, // System clock.
    input wire logic rst_b, // Asynchronous reset, active low.
    i2rs_stream_if.snk in_s, // Filling side.
    i2rs_stream_if.src out_s // Draining side.
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [CW-1:0] count;
    logic [AW-1:0] next_wptr;
    logic [AW-1:0] next_rptr;
    logic [CW-1:0] next_count;
    logic push;
    logic pop;

    // Full and empty come straight from the word count.
    assign in_s.ready = (count != FULL);
    assign out_s.valid = (count != '0);
    assign out_s.data = mem[rptr];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    ////////////////////////////////////////////////////////////////////////
    // Pointer and count update.
    always_comb begin
        next_wptr = wptr;
        next_rptr = rptr;
        next_count = count;
        if (push) begin
            next_wptr = (wptr == LAST) ? '0 : wptr + 1'b1;
        end
        if (pop) begin
            next_rptr = (rptr == LAST) ? '0 : rptr + 1'b1;
        end
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    // Storage has no reset; only written words are ever shown.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wptr] <= in_s.data;
        end
    end

    // Pointers and count are registered.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else begin
            wptr <= next_wptr;
            rptr <= next_rptr;
            count <= next_count;
        end
    end
endmodule // i2rs_fifo
`default_nettype wire

// *** testbench/i2rs_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module i2rs_host_model #(
    parameter int QTR = 6 // System clocks per quarter bit.
) (
    input wire logic clk, // System clock.
    input wire logic sda, // Resolved data line level.
    output logic scl, // Bus clock, idle high.
    output logic sda_low // High while the host pulls data low.
);
    // Both lines start released, so the pull-ups hold them high.
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Waits a quarter bit, moving only after falling clock edges.
    task automatic qtr();
        repeat (QTR) @(negedge clk);
    endtask
    // Falling data with the clock high; from a low clock it is a repeated start.
    task automatic start_cond();
        sda_low = 1'b0;
        qtr();
        scl = 1'b1;
        qtr();
        sda_low = 1'b1;
        qtr();
        scl = 1'b0;
        qtr();
    endtask
    // Rising data with the clock high ends the transfer.
    task automatic stop_cond();
        sda_low = 1'b1;
        qtr();
        scl = 1'b1;
        qtr();
        sda_low = 1'b0;
        qtr();
    endtask
    // Data moves only while the clock is low and is sampled mid-high.
    task automatic bit_cycle(input logic b, output logic seen);
        sda_low = ~b;
        qtr();
        scl = 1'b1;
        qtr();
        seen = sda;
        qtr();
        scl = 1'b0;
        qtr();
    endtask
    // Eight bits MSB first, then the ninth; a one there releases the line.
    task automatic byte_xfer(input logic [7:0] tx, input logic ack_in,
                             output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(tx[i], rx[i]);
        end
        bit_cycle(ack_in, ack);
    endtask
endmodule // i2rs_host_model
`default_nettype wire

// *** testbench/i2rs_slave_test.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "i2rs_regs.svh"
module i2rs_slave_test;
    logic clk, rst_b, scl, host_low, sda_line, sda_out, sda_oe, ad_pin, aux, aux_exp;
    logic [7:0] rd_index, rd_data, wr_index, wr_data;
    logic wr_valid, wr_ready, stall, sc_out, sc_oe, sd_out, sd_oe;
    logic [15:0] exp_q[$], got_q[$];
    int n_mismatch = 0;
    int n_checks = 0;
    i2rs_slave u_dut (
        .clk(clk),
        .rst_b(rst_b),
        .scl_in(scl),
        .sda_in(sda_line),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .address_select_pin(ad_pin),
        .rd_index(rd_index),
        .rd_data(rd_data),
        .wr_valid(wr_valid),
        .wr_index(wr_index),
        .wr_data(wr_data),
        .wr_ready(wr_ready),
        .aux_io_level_select(aux),
        .secondary_bus_clock_in(1'b1),
        .secondary_bus_clock_out(sc_out),
        .secondary_bus_clock_oe(sc_oe),
        .secondary_bus_data_in(1'b1),
        .secondary_bus_data_out(sd_out),
        .secondary_bus_data_oe(sd_oe)
    );
    i2rs_host_model u_host (.clk(clk), .sda(sda_line), .scl(scl), .sda_low(host_low));
    ////////////////////////////////////////////////////////////////////////////
    // Clock, pulled-up data wire and a user register file that is a pure function.
    initial clk = 1'b0;
    always #20 clk = ~clk;
    assign sda_line = ~(host_low | (sda_oe & ~sda_out));
    assign rd_data = rd_index ^ 8'h5a;
    // Random back-pressure on the user side, and a log of accepted words.
    always @(negedge clk) begin
        wr_ready <= ~stall & ($urandom_range(0, 3) != 0);
    end
    always @(posedge clk) begin
        if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
            got_q.push_back({wr_index, wr_data});
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Comparison helpers, one for each width of result.
    task automatic check_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Read value: the level select register is internal, the rest come from the user.
    function automatic logic [7:0] exp_rd(input logic [7:0] idx);
        return (idx == `I2RS_AUX_INDEX) ? ({7'h00, aux_exp} << `I2RS_AUX_BIT) : idx ^ 8'h5a;
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // Start condition, then an address byte whose ninth bit is checked.
    task automatic open_addr(input logic [6:0] a, input logic rw, input logic exp_ack);
        logic [7:0] rx;
        logic ack;
        u_host.start_cond();
        u_host.byte_xfer({a, rw}, 1'b1, rx, ack);
        check_bit("addr_ack", exp_ack, ack);
    endtask
    // Write burst; bytes from full_at on are expected to be refused.
    task automatic write_burst(input logic [7:0] idx, input logic [7:0] d0, input int n,
                               input int full_at);
        logic [7:0] rx, d;
        logic ack;
        open_addr({`I2RS_ADDR_HI, ad_pin}, 1'b0, 1'b0);
        u_host.byte_xfer(idx, 1'b1, rx, ack);
        check_bit("index_ack", 1'b0, ack);
        for (int i = 0; i < n; i++) begin
            d = (i == 0) ? d0 : 8'($urandom);
            u_host.byte_xfer(d, 1'b1, rx, ack);
            check_bit("data_ack", i >= full_at, ack);
            if (i < full_at) begin
                exp_q.push_back({idx + 8'(i), d});
            end
        end
        u_host.stop_cond();
    endtask
    // Lets the user take every word, then compares the words and the level bit.
    task automatic drain_and_compare();
        logic [15:0] e, g;
        int t;
        stall = 1'b0;
        t = 0;
        while (got_q.size() < exp_q.size() && t < 2000) begin
            @(negedge clk);
            t++;
        end
        repeat (4) @(negedge clk);
        check_byte("word_count", 8'(exp_q.size()), 8'(got_q.size()));
        while (exp_q.size() > 0 && got_q.size() > 0) begin
            e = exp_q.pop_front();
            g = got_q.pop_front();
            check_byte("wr_index", e[15:8], g[15:8]);
            check_byte("wr_data", e[7:0], g[7:0]);
            if (e[15:8] == `I2RS_AUX_INDEX) begin
                aux_exp = e[`I2RS_AUX_BIT];
            end
        end
        exp_q.delete();
        got_q.delete();
        check_bit("aux_level", aux_exp, aux);
    endtask
    // Index write, repeated start, read burst ended by a refusal and a stop.
    task automatic read_burst(input logic [7:0] idx, input int n);
        logic [7:0] rx;
        logic ack;
        open_addr({`I2RS_ADDR_HI, ad_pin}, 1'b0, 1'b0);
        u_host.byte_xfer(idx, 1'b1, rx, ack);
        check_bit("index_ack", 1'b0, ack);
        open_addr({`I2RS_ADDR_HI, ad_pin}, 1'b1, 1'b0);
        for (int i = 0; i < n; i++) begin
            u_host.byte_xfer(8'hff, i == n - 1, rx, ack);
            check_byte("rd_byte", exp_rd(idx + 8'(i)), rx);
        end
        check_bit("released", 1'b0, sda_oe);
        u_host.stop_cond();
    endtask
    // Foreign address traffic, restart out of it, and silence after a stop.
    task automatic foreign_test();
        logic [7:0] rx;
        logic ack;
        open_addr({`I2RS_ADDR_HI, ~ad_pin}, 1'b0, 1'b1);
        u_host.byte_xfer(8'h00, 1'b1, rx, ack);
        check_bit("ignored_ack", 1'b1, ack);
        open_addr({`I2RS_ADDR_HI, ~ad_pin}, 1'b1, 1'b1);
        u_host.byte_xfer(8'hff, 1'b1, rx, ack);
        check_byte("ignored_rd", 8'hff, rx);
        open_addr({`I2RS_ADDR_HI, ad_pin}, 1'b0, 1'b0);
        u_host.stop_cond();
        u_host.byte_xfer({`I2RS_ADDR_HI, ad_pin, 1'b0}, 1'b1, rx, ack);
        check_bit("idle_ack", 1'b1, ack);
        u_host.stop_cond();
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence of tests.
    initial begin
        logic [7:0] idx;
        int n;
        rst_b = 1'b0;
        ad_pin = 1'b0;
        stall = 1'b0;
        aux_exp = `I2RS_AUX_RESET;
        n = $urandom(14884);
        repeat (6) @(negedge clk);
        rst_b = 1'b1;
        @(negedge clk);
        check_bit("aux_reset", 1'b0, aux);
        check_bit("sda_reset", 1'b0, sda_oe);
        $display("test reset done");
        for (int a = 0; a < 2; a++) begin
            ad_pin = a[0];
            write_burst(8'h22, 8'($urandom), 1, 255);
            drain_and_compare();
            read_burst(8'h22, 1);
        end
        $display("test address_pin done");
        write_burst(`I2RS_AUX_INDEX, 8'h04, 1, 255);
        drain_and_compare();
        read_burst(`I2RS_AUX_INDEX, 1);
        write_burst(`I2RS_AUX_INDEX, 8'hfb, 1, 255);
        drain_and_compare();
        $display("test level_select done");
        read_burst(8'hfe, 3);
        for (int k = 0; k < 6; k++) begin
            idx = 8'($urandom);
            n = $urandom_range(1, 4);
            write_burst(idx, 8'($urandom), n, 255);
            drain_and_compare();
            read_burst(idx, n);
        end
        $display("test random_bursts done");
        foreign_test();
        $display("test foreign done");
        stall = 1'b1;
        repeat (2) @(negedge clk);
        write_burst(8'h40, 8'h11, `I2RS_FIFO_DEPTH + 2, `I2RS_FIFO_DEPTH + 1);
        drain_and_compare();
        check_bit("aux_clk_oe", 1'b0, sc_oe);
        check_bit("aux_data_oe", 1'b0, sd_oe);
        check_bit("aux_clk_out", 1'b0, sc_out);
        check_bit("aux_data_out", 1'b0, sd_out);
        $display("test buffer_full done");
        tally_and_finish();
    end
    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (80000) @(posedge clk);
        n_mismatch++;
        $display("[ERR] watchdog expected finish seen timeout");
        tally_and_finish();
    end
endmodule // i2rs_slave_test
`default_nettype wire
